// file: include/cav_pkg.sv
// Purpose: Shared constants and types for the CA reference mode register.
// Assumes: Register content is one byte; two set-point copies.
// Notes: Levels are reported in tenths of a percent of the I/O supply.
package cav_pkg;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int CAV_LEVEL_W = 6;
    localparam int CAV_REG_W = 8;
    localparam int CAV_RANGE_BIT = 6;
    localparam int CAV_RSVD_BIT = 7;
    localparam int CAV_MV_W = 10;
    localparam int CAV_NUM_SP = 2;

    // ************************************************************
    // Reset values and code limits
    // ************************************************************
    localparam logic [5:0] CAV_LEVEL_RST = 6'h1d;
    localparam logic CAV_RANGE_RST = 1'b1;
    localparam logic [5:0] CAV_LEVEL_MAX = 6'h32;

    // ************************************************************
    // Level decode, tenths of a percent
    // ************************************************************
    localparam logic [9:0] CAV_RANGE0_BASE = 10'h096;
    localparam logic [9:0] CAV_RANGE1_BASE = 10'h149;
    localparam logic [9:0] CAV_STEP = 10'h006;
    // Decoded default level, 50.3 percent
    localparam logic [9:0] CAV_LEVEL_DEC_RST = 10'h1f7;

    // One stored set-point copy
    typedef struct packed {
        logic range_sel;
        logic [5:0] level;
    } cav_setting_t;

    localparam cav_setting_t CAV_SETTING_RST = '{range_sel: CAV_RANGE_RST, level: CAV_LEVEL_RST};

endpackage

// file: verilog/cav_mode_reg.sv
// Purpose: CA reference mode register with two set-point copies.
// Assumes: Commands for this register arrive on pins beside the command clock.
// Notes: Command clock is sampled by mclk_i; commands taken on its rising edge.
// What this block does
// (RL1) Hold six-bit level code in bits five..zero
// (RL2) Bit six selects range; range one default
// (RL3) Default code 011101 in range one
// (RL4) Range zero: fifteen to forty-five percent
// (RL5) Range one: 32.9 to 62.9 percent
// (RL6) Read drives register bits onto data lines
// (RL7) Reserved bit and unused lines read zero
// (RL8) Write-target select picks copy to write
// (RL9) Two copies; write changes only chosen one
// (RL10) Read returns write-target copy
// (RL11) Operate select picks the copy in use
// (RL12) Inactive copy ignored, freely rewritable
// (RL13) Controller writes range with level together
// (RL14) Values retained until overwrite or reset
// (RL15) Controller avoids reserved codes above 110010
`timescale 1ns/1ps
module cav_mode_reg
    import cav_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Command pins
    input wire logic cmd_clk_i,
    input wire logic mode_reg_write_cmd_i,
    input wire logic mode_reg_read_cmd_i,
    input wire logic [cav_pkg::CAV_REG_W-1:0] op_i,
    // Set-point control bits
    input wire logic setpoint_write_target_i,
    input wire logic setpoint_operate_select_i,
    // Read data pins
    output logic [cav_pkg::CAV_REG_W-1:0] dq_o,
    output logic dq_oe_o,
    // Active setting
    output cav_pkg::cav_setting_t ca_reference_setting_o,
    output logic [cav_pkg::CAV_MV_W-1:0] ca_reference_level_o,
    output logic reserved_code_o
);
    import cav_pkg::*;

    // ************************************************************
    // Level decode
    // ************************************************************
    function automatic logic [CAV_MV_W-1:0] decode_level(input cav_setting_t s);
        logic [CAV_MV_W-1:0] base;
        logic [CAV_MV_W-1:0] step;
        base = s.range_sel ? CAV_RANGE1_BASE : CAV_RANGE0_BASE;
        step = CAV_MV_W'(CAV_STEP * {4'h0, s.level});
        return CAV_MV_W'(base + step);
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic ck_s1_r, ck_s2_r, ck_s3_r;
    logic wr_s1_r, wr_s2_r, rd_s1_r, rd_s2_r;
    logic [CAV_REG_W-1:0] op_s1_r, op_s2_r;

    // Two flops on every pin, third flop only for edge finding
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ck_s1_r <= 1'b0;
            ck_s2_r <= 1'b0;
            ck_s3_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            op_s1_r <= 8'h00;
            op_s2_r <= 8'h00;
        end else begin
            ck_s1_r <= cmd_clk_i;
            ck_s2_r <= ck_s1_r;
            ck_s3_r <= ck_s2_r;
            wr_s1_r <= mode_reg_write_cmd_i;
            wr_s2_r <= wr_s1_r;
            rd_s1_r <= mode_reg_read_cmd_i;
            rd_s2_r <= rd_s1_r;
            op_s1_r <= op_i;
            op_s2_r <= op_s1_r;
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    wire ck_rise_w = ck_s2_r & ~ck_s3_r;
    wire wr_take_w = ck_rise_w & wr_s2_r;
    wire rd_take_w = ck_rise_w & rd_s2_r & ~wr_s2_r;
    // Range and level always taken together from one write
    wire cav_setting_t wr_val_w = '{range_sel: op_s2_r[CAV_RANGE_BIT], // RL2 RL13
                                    level: op_s2_r[CAV_LEVEL_W-1:0]}; // RL1
    wire rsvd_w = wr_take_w & (op_s2_r[CAV_LEVEL_W-1:0] > CAV_LEVEL_MAX); // RL15

    // ************************************************************
    // Set-point copies
    // ************************************************************
    cav_setting_t copy_r [CAV_NUM_SP];

    // One storage copy per set point, written only when targeted
    generate
        for (genvar sp = 0; sp < CAV_NUM_SP; sp++) begin : g_copy
            wire sel_w = (setpoint_write_target_i == 1'(sp)); // RL8
            always_ff @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    copy_r[sp] <= CAV_SETTING_RST; // RL3 RL14
                end else if (wr_take_w && sel_w) begin
                    copy_r[sp] <= wr_val_w; // RL9
                end
            end
        end
    endgenerate

    // Copies selected for access and for operation
    wire cav_setting_t tgt_w = copy_r[setpoint_write_target_i]; // RL10
    wire cav_setting_t act_w = copy_r[setpoint_operate_select_i]; // RL11 RL12

    // ************************************************************
    // Read data and active outputs
    // ************************************************************
    logic [CAV_REG_W-1:0] dq_r;
    logic dq_oe_r;
    logic rsvd_r;
    cav_setting_t act_r;
    logic [CAV_MV_W-1:0] lvl_r;

    // Read answer lasts one cycle; bit 7 and idle lines are zero
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dq_r <= 8'h00;
            dq_oe_r <= 1'b0;
            rsvd_r <= 1'b0;
            act_r <= CAV_SETTING_RST;
            lvl_r <= CAV_LEVEL_DEC_RST;
        end else begin
            dq_r <= rd_take_w ? {1'b0, tgt_w} : 8'h00; // RL6 RL7
            dq_oe_r <= rd_take_w;
            rsvd_r <= rsvd_w;
            act_r <= act_w;
            lvl_r <= decode_level(act_w); // RL4 RL5
        end
    end

    assign dq_o = dq_r;
    assign dq_oe_o = dq_oe_r;
    assign reserved_code_o = rsvd_r;
    assign ca_reference_setting_o = act_r;
    assign ca_reference_level_o = lvl_r;

    // ************************************************************
    // Checks
    // ************************************************************
    a_read_rsvd_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL7
        !dq_o[CAV_RSVD_BIT] && (dq_oe_o || dq_o == 8'h00))
        else $error("reserved read bit or idle data not zero");

    a_read_target: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL10
        rd_take_w |=> dq_oe_o && dq_o[6:0] == $past(tgt_w))
        else $error("read did not return write-target copy");

    a_read_one_cycle: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6
        dq_oe_o |=> !dq_oe_o)
        else $error("read answer held too long");

    a_write_copy: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL8
        wr_take_w |=> copy_r[$past(setpoint_write_target_i)] == $past(wr_val_w))
        else $error("write did not reach targeted copy");

    a_other_kept0: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL9
        (wr_take_w && setpoint_write_target_i) |=> $stable(copy_r[0]))
        else $error("untargeted copy 0 changed");

    a_other_kept1: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL9
        (wr_take_w && !setpoint_write_target_i) |=> $stable(copy_r[1]))
        else $error("untargeted copy 1 changed");

    a_retain_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL14
        !wr_take_w |=> $stable(copy_r[0]) && $stable(copy_r[1]))
        else $error("copy changed without a write");

    a_active_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL11
        ##1 ca_reference_setting_o == $past(copy_r[setpoint_operate_select_i]))
        else $error("active setting not from operate copy");

    a_level_range0: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL4
        (!act_w.range_sel && act_w.level == CAV_LEVEL_MAX) |=> ca_reference_level_o == 10'h1c2)
        else $error("range 0 top code not 45.0 percent");

    a_level_range1: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL5
        (act_w.range_sel && act_w.level == 6'h00) |=> ca_reference_level_o == 10'h149)
        else $error("range 1 bottom code not 32.9 percent");

    a_reset_default: assert property (@(posedge mclk_i) // RL3
        $fell(sys_rst_i) |-> copy_r[0] == CAV_SETTING_RST && copy_r[1] == CAV_SETTING_RST
                             && ca_reference_level_o == 10'h1f7)
        else $error("defaults not restored by reset");

    // Reserved codes are stored but raise a one-cycle pulse
    a_flag_reserved: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL15
        (wr_take_w && (op_s2_r[CAV_LEVEL_W-1:0] > CAV_LEVEL_MAX)) |=> reserved_code_o)
        else $error("reserved code write not flagged");

    a_flag_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL15
        !wr_take_w |=> !reserved_code_o)
        else $error("reserved flag without a write");

    // A read that comes with a write gets no answer
    a_read_refused: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL6
        (ck_rise_w && wr_s2_r) |=> !dq_oe_o)
        else $error("read answered during a write");

    a_range_store: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL2
        wr_take_w |=> copy_r[$past(setpoint_write_target_i)].range_sel
                      == $past(op_s2_r[CAV_RANGE_BIT]))
        else $error("range bit not stored with level");

    a_level_base0: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL4
        (!act_w.range_sel && act_w.level == 6'h00) |=> ca_reference_level_o == CAV_RANGE0_BASE)
        else $error("range 0 bottom code not 15.0 percent");

endmodule

// file: testbench/cav_ctrl_model.sv
// Purpose: Controller model that issues mode register commands.
// Assumes: Command clock of 80 ns that stands still between frames.
// Notes: Read answers are queued in rd_q for the bench.
`timescale 1ns/1ps
module cav_ctrl_model (
    // Clock and read answer
    input wire logic mclk_i,
    input wire logic [7:0] dq_i,
    input wire logic dq_oe_i,
    // Command pins
    output logic cmd_clk_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] op_o
);
    // ****************
    // Command framing
    // ****************
    logic [7:0] rd_q[$];
    // Pins idle, clock low
    initial begin
        {cmd_clk_o, wr_o, rd_o, op_o} = '0;
    end
    // One frame; range and level always go out in one byte
    task automatic issue(input logic w, input logic r, input logic [7:0] op);
        @(posedge mclk_i);
        {wr_o, rd_o, op_o} <= {w, r, op};
        repeat (4) @(posedge mclk_i);
        cmd_clk_o <= 1'b1;
        repeat (4) @(posedge mclk_i);
        cmd_clk_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        {wr_o, rd_o, op_o} <= {2'h0, ~op};  // Released op lines show the inverse; wr and rd go low
        repeat (2) @(posedge mclk_i);
    endtask
    // Collect each read answer
    always @(posedge mclk_i) begin
        if (dq_oe_i) rd_q.push_back(dq_i);
    end
endmodule

// file: testbench/test_cav_mode_reg.sv
// Purpose: Self-checking bench for the CA reference mode register.
// Assumes: Controller model drives the command pins.
// Notes: Reference copies kept in cp, compared after every command.
`timescale 1ns/1ps
module test_cav_mode_reg;
    import cav_pkg::*;
    // ****************
    // Signals and model
    // ****************
    logic mclk_i, sys_rst_i, cmd_clk, wr, rd, tgt, opsel, rsv, dq_oe;
    logic [7:0] op, dq, v;
    cav_setting_t setting;
    logic [9:0] level;
    logic [6:0] cp [2];
    int n_mismatch = 0, checks = 0, seed = 71462, n_rsv = 0, exp_rsv = 0, r;
    // Clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    cav_mode_reg dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_clk_i(cmd_clk),
        .mode_reg_write_cmd_i(wr), .mode_reg_read_cmd_i(rd), .op_i(op),
        .setpoint_write_target_i(tgt), .setpoint_operate_select_i(opsel), .dq_o(dq),
        .dq_oe_o(dq_oe), .ca_reference_setting_o(setting), .ca_reference_level_o(level),
        .reserved_code_o(rsv));
    cav_ctrl_model partner_u (.mclk_i(mclk_i), .dq_i(dq), .dq_oe_i(dq_oe),
        .cmd_clk_o(cmd_clk), .wr_o(wr), .rd_o(rd), .op_o(op));
    // Count reserved-code flags
    always @(posedge mclk_i) begin
        if (rsv === 1'b1) n_rsv++;
    end
    // Compare one value
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Active copy and its decoded level
    task automatic chk_active();
        repeat (2) @(posedge mclk_i);
        #1;
        chk("setting", {9'h0, setting}, {9'h0, cp[opsel]});
        chk("level", {6'h0, level}, {6'h0, (cp[opsel][6] ? CAV_RANGE1_BASE : CAV_RANGE0_BASE)
            + CAV_STEP * cp[opsel][5:0]});
    endtask
    // Read one copy back
    task automatic rd_chk(input logic t);
        @(posedge mclk_i);
        tgt <= t;
        partner_u.issue(1'b0, 1'b1, 8'h00);
        chk("answers", 16'(partner_u.rd_q.size()), 16'h1);
        v = (partner_u.rd_q.size() > 0) ? partner_u.rd_q.pop_front() : 8'hxx;
        chk("read", {8'h0, v}, {9'h0, cp[t]});
        chk("idle dq", {8'h0, dq}, 16'h0);
    endtask
    // Write one copy
    task automatic wr_cmd(input logic t, input logic [7:0] o);
        @(posedge mclk_i);
        tgt <= t;
        partner_u.issue(1'b1, 1'b0, o);
        cp[t] = o[6:0];
        if (o[5:0] > CAV_LEVEL_MAX) exp_rsv++;
        chk_active();
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {sys_rst_i, tgt, opsel} = 3'h4;
        cp = '{CAV_SETTING_RST, CAV_SETTING_RST};
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk_active();
        rd_chk(1'b0);
        rd_chk(1'b1);
        for (int i = 0; i < 8; i++) begin
            wr_cmd(i[0], {1'b1, i[1], i[2] ? 6'h32 : 6'h00});
            rd_chk(i[0]);
        end
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            v = r[7:0];
            v[5:0] = 6'(v[5:0] % 6'h33);
            @(posedge mclk_i);
            opsel <= r[9];
            wr_cmd(r[8], v);
            rd_chk(r[10]);
        end
        wr_cmd(~opsel, 8'h3f);
        rd_chk(~opsel);
        partner_u.issue(1'b1, 1'b1, 8'h05);
        cp[tgt] = 7'h05;
        chk("refused read", 16'(partner_u.rd_q.size()), 16'h0);
        chk_active();
        rd_chk(tgt);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        cp = '{CAV_SETTING_RST, CAV_SETTING_RST};
        repeat (3) @(posedge mclk_i);
        chk_active();
        rd_chk(1'b1);
        rd_chk(1'b0);
        chk("flags", 16'(n_rsv), 16'(exp_rsv));
        end_sim();
    end
    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule
